// ===== rtl/sao_pkg.sv
package sao_pkg;

	// ------------------------------------------------------------
	// Widths and ranges
	// ------------------------------------------------------------
	localparam int NCH = 2;
	localparam int VW  = 18;
	localparam int HW  = 16;
	localparam int DW  = 13;
	localparam int AW  = 8;
	localparam int TW  = 23;
	localparam logic signed [VW-1:0] SP_MIN   = -18'sd9999;
	localparam logic signed [VW-1:0] SP_MAX   = 18'sd99999;
	localparam logic [HW-1:0]        HYST_MIN = 16'h0001;
	localparam logic [HW-1:0]        HYST_MAX = 16'hea5f;
	localparam logic [DW-1:0]        DLY_MAX  = 13'h176f;

	// ------------------------------------------------------------
	// Register map, byte addresses
	// ------------------------------------------------------------
	localparam logic [AW-1:0] OFF_CFG   = 8'h00;
	localparam logic [AW-1:0] OFF_SP    = 8'h04;
	localparam logic [AW-1:0] OFF_HYST  = 8'h08;
	localparam logic [AW-1:0] OFF_OND   = 8'h0c;
	localparam logic [AW-1:0] OFF_OFFD  = 8'h10;
	localparam logic [AW-1:0] CH_STRIDE = 8'h20;
	localparam logic [AW-1:0] OFF_CTRL  = 8'h40;
	localparam logic [AW-1:0] OFF_STAT  = 8'h44;

	// Control word fields
	localparam int CTRL_SER_LSB = 0;
	localparam int CTRL_RED_BIT = 2;
	// Status word fields
	localparam int STAT_OUT_LSB  = 0;
	localparam int STAT_PEND_LSB = 2;
	localparam int STAT_ARM_LSB  = 4;
	localparam int STAT_FLT_BIT  = 6;
	localparam int STAT_PRS_LSB  = 8;
	localparam int STAT_DP_LSB   = 10;

	// ------------------------------------------------------------
	// Modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ACT_HI_BAL, ACT_LO_BAL, ACT_HI_UNB, ACT_LO_UNB
	} sao_act_t;

	typedef enum logic [1:0] {
		RM_AUTO, RM_LATCH_IMM, RM_LATCH_DEF
	} sao_rmode_t;

	// Channel configuration word, enable in bit 0
	typedef struct packed {
		logic       color_chg;
		logic       burnout_on;
		logic       standby;
		logic       disp_rst_en;
		sao_rmode_t rmode;
		sao_act_t   action;
		logic       enable;
	} sao_cfg_t;

	localparam int CFG_W = 9;
	localparam sao_cfg_t CFG_RST = '{
		color_chg: 1'b0, burnout_on: 1'b0, standby: 1'b0,
		disp_rst_en: 1'b0, rmode: RM_AUTO, action: ACT_HI_BAL,
		enable: 1'b0};
	localparam logic signed [VW-1:0] SP_RST   = 18'sh00000;
	localparam logic [HW-1:0]        HYST_RST = 16'h0001;
	localparam logic [DW-1:0]        DLY_RST  = 13'h0000;

	// Measurement update from the input stage
	typedef struct packed {
		logic                 strobe;
		logic signed [VW-1:0] value;
		logic                 probe_fault;
	} sao_meas_t;

	// Front button and user input reset sources
	typedef struct packed {
		logic button;
		logic user;
		logic button_disp;
		logic user_disp;
		logic input_shown;
	} sao_man_t;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint CLK_PS  = 20000;
	localparam longint TICK_PS = 100000000000;
	localparam int TICK_CYC = int'(TICK_PS / CLK_PS);

endpackage

// ===== rtl/sao_delay.sv
`timescale 1ns/10ps
module sao_delay
	import sao_pkg::*;
#(
	parameter int DLY_W = sao_pkg::DW
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             tick,
	input  wire logic             req,
	input  wire logic [DLY_W-1:0] on_dly,
	input  wire logic [DLY_W-1:0] off_dly,
	output logic                  q
);

	logic [DLY_W-1:0] cnt_ff;
	logic [DLY_W-1:0] nxt_cnt;
	logic             q_ff;
	logic             nxt_q;
	logic [DLY_W-1:0] limit;

	// ------------------------------------------------------------
	// Qualify a level change for a number of tenth-second ticks
	// ------------------------------------------------------------
	// Counter restarts if the request falls back, so a short
	// transient never reaches the output
	always_comb begin
		limit   = req ? on_dly : off_dly;
		nxt_cnt = cnt_ff;
		nxt_q   = q_ff;
		if (req == q_ff) begin
			nxt_cnt = '0;
		end else if (limit == '0) begin
			nxt_q   = req;
			nxt_cnt = '0;
		end else if (tick) begin
			if (cnt_ff + 1'b1 >= limit) begin
				nxt_q   = req;
				nxt_cnt = '0;
			end else begin
				nxt_cnt = cnt_ff + 1'b1;
			end
		end
	end

	// Counter and delayed level
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_ff <= '0;
			q_ff   <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			q_ff   <= nxt_q;
		end
	end

	assign q = q_ff;

endmodule

// ===== rtl/sao_top.sv
// Contract
// - Signed threshold limited to -9999..99999
// - Nonzero hysteresis limited to 1..59999
// - High/low balanced and high/low unbalanced actions
// - Unbalanced band below high, above low
// - On-delay holds output off, tenths
// - Off-delay keeps output on, tenths
// - Auto mode turns off at off point
// - Auto manual reset forces off until retrigger
// - Latch cleared only by reset sources
// - Immediate latch reset clears until retrigger
// - Power up leaves latched output off
// - Deferred reset waits for off crossing
// - Power cycle always drops pending
// - Display reset also resets output when enabled
// - Combined reset needs assignment and shown input
// - Standby blocks output until first crossing
// - Probe fault forces programmed burn-out state
// - Backlit colour toggles on output change
// - Second channel has its own enable
// - Card sets channel count, independent sets
// - Decimal position follows display setting
// - Outputs absent without output card
`timescale 1ns/10ps
module sao_top
	import sao_pkg::*;
#(
	parameter int NUM_CH   = sao_pkg::NCH,
	parameter int TICK_LEN = sao_pkg::TICK_CYC
) (
	input  wire logic                     REF_CLK,
	input  wire logic                     NRST,
	input  wire logic                     PSEL,
	input  wire logic                     PENABLE,
	input  wire logic                     PWRITE,
	input  wire logic [sao_pkg::AW-1:0]   PADDR,
	input  wire logic [31:0]              PWDATA,
	output logic      [31:0]              PRDATA,
	output logic                          PREADY,
	output logic                          PSLVERR,
	input  wire sao_pkg::sao_meas_t       MEAS,
	input  wire sao_pkg::sao_man_t        MAN_RST,
	input  wire logic [1:0]               CARD_CHANNELS,
	input  wire logic                     BACKLIT,
	input  wire logic [2:0]               DECIMAL_POS,
	output logic      [NUM_CH-1:0]        SP_OUT,
	output logic                          BACKLIGHT_RED
);

	import sao_pkg::*;

	localparam int XW = VW + 2;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Returns {on_hit, off_hit} for one measured value
	function automatic logic [1:0] hits(
		input sao_act_t             act,
		input logic signed [VW-1:0] sp,
		input logic [HW-1:0]        hy,
		input logic signed [VW-1:0] v
	);
		logic signed [XW-1:0] s;
		logic signed [XW-1:0] h;
		logic signed [XW-1:0] hh;
		logic signed [XW-1:0] x;
		s  = XW'(sp);
		h  = XW'(signed'({1'b0, hy}));
		hh = h >>> 1;
		x  = XW'(v);
		hits = 2'b00;
		unique case (act)
			ACT_HI_BAL: hits = {x >= s + hh, x <= s - hh};
			ACT_LO_BAL: hits = {x <= s - hh, x >= s + hh};
			ACT_HI_UNB: hits = {x >= s, x <= s - h};
			ACT_LO_UNB: hits = {x <= s, x >= s + h};
		endcase
	endfunction

	// Decoded register selection: slot 0..4 per channel, 5 ctrl,
	// 6 status, 7 unmapped
	function automatic logic [3:0] decode(input logic [AW-1:0] a);
		logic [AW-1:0] rel;
		decode = 4'h7;
		if (a == OFF_CTRL) begin
			decode = 4'h5;
		end else if (a == OFF_STAT) begin
			decode = 4'h6;
		end else if (a < OFF_CTRL && a[1:0] == 2'b00) begin
			rel = a & (CH_STRIDE - 1'b1);
			if (rel <= OFF_OFFD && 32'(a / CH_STRIDE) < NUM_CH) begin
				decode = {1'b0, rel[4:2]};
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	sao_cfg_t             cfg_ff  [NUM_CH];
	logic signed [VW-1:0] sp_ff   [NUM_CH];
	logic [HW-1:0]        hyst_ff [NUM_CH];
	logic [DW-1:0]        ond_ff  [NUM_CH];
	logic [DW-1:0]        offd_ff [NUM_CH];
	logic                 red_ff;
	logic [NUM_CH-1:0]    ser_ff;
	logic [31:0]          rdata_ff;

	logic [3:0]           sel;
	int                   ch_a;
	logic                 wr_acc;
	logic                 bad_val;
	logic signed [VW-1:0] w_sp;
	logic [HW-1:0]        w_hy;
	logic [DW-1:0]        w_dl;

	assign sel    = decode(PADDR);
	assign ch_a   = int'(PADDR / CH_STRIDE) % NUM_CH;
	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign w_sp   = PWDATA[VW-1:0];
	assign w_hy   = PWDATA[HW-1:0];
	assign w_dl   = PWDATA[DW-1:0];

	// Out-of-range setup values are refused and the old one kept
	always_comb begin
		unique case (sel)
			4'h1: bad_val = w_sp < SP_MIN || w_sp > SP_MAX;
			4'h2: bad_val = w_hy < HYST_MIN || w_hy > HYST_MAX;
			4'h3: bad_val = w_dl > DLY_MAX;
			4'h4: bad_val = w_dl > DLY_MAX;
			default: bad_val = 1'b0;
		endcase
	end

	// Zero-wait slave; read data captured in the setup cycle
	assign PREADY  = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && (sel == 4'h7 ||
		(PWRITE && sel == 4'h6) || (PWRITE && bad_val));
	assign PRDATA  = rdata_ff;

	// Per-channel setup words, independent for each channel
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			for (int i = 0; i < NUM_CH; i++) begin
				cfg_ff[i]  <= CFG_RST;
				sp_ff[i]   <= SP_RST;
				hyst_ff[i] <= HYST_RST;
				ond_ff[i]  <= DLY_RST;
				offd_ff[i] <= DLY_RST;
			end
		end else if (wr_acc && !bad_val) begin
			unique case (sel)
				4'h0: cfg_ff[ch_a]  <= sao_cfg_t'(PWDATA[CFG_W-1:0]);
				4'h1: sp_ff[ch_a]   <= w_sp;
				4'h2: hyst_ff[ch_a] <= w_hy;
				4'h3: ond_ff[ch_a]  <= w_dl;
				4'h4: offd_ff[ch_a] <= w_dl;
				default: ;
			endcase
		end
	end

	// Control word: colour bit and one-cycle serial reset strobes
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			red_ff <= 1'b0;
			ser_ff <= '0;
		end else begin
			ser_ff <= '0;
			if (wr_acc && sel == 4'h5) begin
				red_ff <= PWDATA[CTRL_RED_BIT];
				ser_ff <= PWDATA[CTRL_SER_LSB +: NUM_CH];
			end
		end
	end

	// ------------------------------------------------------------
	// Manual reset sources
	// ------------------------------------------------------------
	logic btn_q_ff;
	logic usr_q_ff;
	logic btn_press;
	logic usr_press;

	// Both start low, so a source already held at power up
	// counts as a press in the first cycle after release
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			btn_q_ff <= 1'b0;
			usr_q_ff <= 1'b0;
		end else begin
			btn_q_ff <= MAN_RST.button;
			usr_q_ff <= MAN_RST.user;
		end
	end

	assign btn_press = MAN_RST.button && !btn_q_ff;
	assign usr_press = MAN_RST.user && !usr_q_ff;

	// ------------------------------------------------------------
	// Tenth-second tick for the delays
	// ------------------------------------------------------------
	logic [TW-1:0] div_ff;
	logic          tick;

	assign tick = div_ff == TW'(TICK_LEN - 1);

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			div_ff <= '0;
		end else begin
			div_ff <= tick ? '0 : div_ff + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Setpoint channels
	// ------------------------------------------------------------
	logic [NUM_CH-1:0] out_ff;
	logic [NUM_CH-1:0] nxt_out;
	logic [NUM_CH-1:0] pend_ff;
	logic [NUM_CH-1:0] armed_ff;
	logic [NUM_CH-1:0] present;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		logic       tgt_ff;
		logic       dq;
		logic       blk_ff;
		logic       lat_ff;
		logic [1:0] hit;
		logic       man;
		logic       eff_arm;
		logic       core;
		sao_cfg_t   cf;

		assign cf  = cfg_ff[c];
		assign hit = hits(cf.action, sp_ff[c], hyst_ff[c], MEAS.value);

		// Channel exists only if the card carries it and, for the
		// second one, it is switched on
		assign present[c] = 32'(CARD_CHANNELS) > c &&
			(c == 0 || cf.enable);

		// A display-reset press only counts when that source is
		// assigned to display reset and the input is on view
		assign man = cf.disp_rst_en ?
			(btn_press && MAN_RST.button_disp && MAN_RST.input_shown) ||
			(usr_press && MAN_RST.user_disp && MAN_RST.input_shown) :
			btn_press || usr_press;

		// Hysteresis target, only moved on a fresh measurement
		always_ff @(posedge REF_CLK) begin
			if (!NRST || !present[c]) begin
				tgt_ff <= 1'b0;
			end else if (MEAS.strobe) begin
				if (hit[1]) begin
					tgt_ff <= 1'b1;
				end else if (hit[0]) begin
					tgt_ff <= 1'b0;
				end
			end
		end

		sao_delay #(
			.DLY_W   (DW)
		) u_dly (
			.clk     (REF_CLK),
			.nrst    (NRST),
			.tick    (tick),
			.req     (tgt_ff),
			.on_dly  (ond_ff[c]),
			.off_dly (offd_ff[c]),
			.q       (dq)
		);

		// Standby: armed by a reading outside the on zone, so a value
		// already alarming at power up waits for a fresh crossing
		always_ff @(posedge REF_CLK) begin
			if (!NRST || !present[c]) begin
				armed_ff[c] <= 1'b0;
			end else if (MEAS.strobe && !hit[1]) begin
				armed_ff[c] <= 1'b1;
			end
		end
		assign eff_arm = !cf.standby || armed_ff[c];

		// Block after a forced clear until the off point is seen
		always_ff @(posedge REF_CLK) begin
			if (!NRST || !present[c]) begin
				blk_ff <= 1'b0;
			end else if ((man && cf.rmode != RM_LATCH_DEF) ||
					ser_ff[c]) begin
				blk_ff <= 1'b1;
			end else if (!dq) begin
				blk_ff <= 1'b0;
			end
		end

		// Latch; the reset wins over a trigger in the same cycle,
		// and blk_ff is what keeps it off until retriggered
		always_ff @(posedge REF_CLK) begin
			if (!NRST || !present[c]) begin
				lat_ff <= 1'b0;
			end else if (ser_ff[c] ||
					(man && cf.rmode != RM_LATCH_DEF)) begin
				lat_ff <= 1'b0;
			end else if (pend_ff[c] && !dq) begin
				lat_ff <= 1'b0;
			end else if (dq && !blk_ff && eff_arm) begin
				lat_ff <= 1'b1;
			end
		end

		// Deferred clear request; discarded by any power cycle
		always_ff @(posedge REF_CLK) begin
			if (!NRST || !present[c]) begin
				pend_ff[c] <= 1'b0;
			end else if (man && cf.rmode == RM_LATCH_DEF &&
					lat_ff) begin
				pend_ff[c] <= 1'b1;
			end else if (!dq || ser_ff[c]) begin
				pend_ff[c] <= 1'b0;
			end
		end

		// Mode selection; an illegal mode code acts as automatic
		always_comb begin
			unique case (cf.rmode)
				RM_LATCH_IMM: core = lat_ff;
				RM_LATCH_DEF: core = lat_ff;
				default:      core = dq && !blk_ff && eff_arm;
			endcase
			if (!present[c]) begin
				nxt_out[c] = 1'b0;
			end else if (MEAS.probe_fault) begin
				nxt_out[c] = cf.burnout_on;
			end else begin
				nxt_out[c] = core;
			end
		end
	end

	// Registered setpoint outputs
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			out_ff <= '0;
		end else begin
			out_ff <= nxt_out;
		end
	end

	assign SP_OUT = out_ff;

	// ------------------------------------------------------------
	// Backlight colour
	// ------------------------------------------------------------
	logic              swap_ff;
	logic [NUM_CH-1:0] chg;
	logic              blr_ff;

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			chg[i] = (nxt_out[i] != out_ff[i]) && cfg_ff[i].color_chg;
		end
	end

	// Two channels changing together cancel, as two toggles would
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			swap_ff <= 1'b0;
			blr_ff  <= 1'b0;
		end else begin
			if (BACKLIT) begin
				swap_ff <= swap_ff ^ (^chg);
			end
			blr_ff <= BACKLIT ? red_ff ^ swap_ff : red_ff;
		end
	end

	assign BACKLIGHT_RED = blr_ff;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [31:0] rd;

	always_comb begin
		rd = '0;
		unique case (sel)
			4'h0: rd[CFG_W-1:0] = cfg_ff[ch_a];
			4'h1: rd[VW-1:0]    = sp_ff[ch_a];
			4'h2: rd[HW-1:0]    = hyst_ff[ch_a];
			4'h3: rd[DW-1:0]    = ond_ff[ch_a];
			4'h4: rd[DW-1:0]    = offd_ff[ch_a];
			4'h5: rd[CTRL_RED_BIT] = red_ff;
			4'h6: begin
				rd[STAT_OUT_LSB +: NUM_CH]  = out_ff;
				rd[STAT_PEND_LSB +: NUM_CH] = pend_ff;
				rd[STAT_ARM_LSB +: NUM_CH]  = armed_ff;
				rd[STAT_FLT_BIT]            = MEAS.probe_fault;
				rd[STAT_PRS_LSB +: NUM_CH]  = present;
				rd[STAT_DP_LSB +: 3]        = DECIMAL_POS;
			end
			default: rd = '0;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			rdata_ff <= '0;
		end else if (PSEL && !PENABLE) begin
			rdata_ff <= rd;
		end
	end

endmodule

// ===== verification/sao_card_model.sv
`timescale 1ns/10ps
module sao_card_model (
	input  wire logic       clk,
	input  wire logic [1:0] slots,
	input  wire logic [1:0] sp_out,
	output logic      [1:0] channels,
	output logic      [1:0] relay
);
	// ------------------------------------------------------------
	// Fitted channels and relay drive
	// ------------------------------------------------------------
	// Fitted count straps the meter; no card means no outputs
	assign channels = slots;
	// Coil lags a cycle; an unfitted slot never pulls in
	always_ff @(posedge clk) begin
		relay <= sp_out & ((slots == 2'h2) ? 2'b11 : {1'b0, slots == 2'h1});
	end
endmodule

// ===== verification/sao_top_asserts.sv
`timescale 1ns/10ps
module sao_top_asserts
	import sao_pkg::*;
#(
	parameter int NUM_CH   = sao_pkg::NCH,
	parameter int TICK_LEN = sao_pkg::TICK_CYC
) (
	input  wire logic                   REF_CLK,
	input  wire logic                   NRST,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [sao_pkg::AW-1:0] PADDR,
	input  wire logic [31:0]            PWDATA,
	input  wire logic [31:0]            PRDATA,
	input  wire logic                   PREADY,
	input  wire logic                   PSLVERR,
	input  wire sao_pkg::sao_meas_t     MEAS,
	input  wire sao_pkg::sao_man_t      MAN_RST,
	input  wire logic [1:0]             CARD_CHANNELS,
	input  wire logic                   BACKLIT,
	input  wire logic [2:0]             DECIMAL_POS,
	input  wire logic [NUM_CH-1:0]      SP_OUT,
	input  wire logic                   BACKLIGHT_RED
);
	// ------------------------------------------------------------
	// Clocking and helpers
	// ------------------------------------------------------------
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);
	logic ctrl_wr;
	// Control word write in its access cycle
	assign ctrl_wr = PSEL && PENABLE && PWRITE && (PADDR == OFF_CTRL);
	sequence s_ser_clr;
		ctrl_wr && PWDATA[0] && !PSLVERR;
	endsequence
	sequence s_refused;
		PSEL && PENABLE && (PADDR == 8'h14 || PWRITE && PADDR == OFF_STAT);
	endsequence
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_ready_zero_wait: assert property (PREADY == (PSEL && PENABLE))
		else $error("pready not tied to access phase");
	chk_err_in_access: assert property (PSLVERR |-> PSEL && PENABLE)
		else $error("pslverr outside access phase");
	chk_refused_access: assert property (s_refused |-> PSLVERR)
		else $error("refused access without pslverr");
	chk_rdata_holds: assert property
		(!($past(PSEL) && !$past(PENABLE)) |-> $stable(PRDATA))
		else $error("prdata changed without setup cycle");
	chk_no_card_off: assert property
		((CARD_CHANNELS == 2'h0) [*5] |-> SP_OUT == '0)
		else $error("output active with no card");
	chk_one_ch_off: assert property
		((CARD_CHANNELS == 2'h1) [*5] |-> !SP_OUT[1])
		else $error("second output active on one channel card");
	chk_fault_holds: assert property (MEAS.probe_fault [*2] |=> $stable(SP_OUT))
		else $error("output moved during probe fault");
	chk_colour_cause: assert property ($changed(BACKLIGHT_RED) |->
		$past(SP_OUT) != $past(SP_OUT, 2) || $past(ctrl_wr, 2))
		else $error("colour changed without output change");
	chk_serial_clear: assert property (s_ser_clr |-> ##[1:3] !SP_OUT[0])
		else $error("serial reset did not clear output");
	chk_powerup_off: assert property ($rose(NRST) |-> (SP_OUT == '0) [*3])
		else $error("output active right after reset");
endmodule

bind sao_top sao_top_asserts #(.NUM_CH(NUM_CH), .TICK_LEN(TICK_LEN)) u_chk (
	.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .MEAS(MEAS), .MAN_RST(MAN_RST),
	.CARD_CHANNELS(CARD_CHANNELS), .BACKLIT(BACKLIT),
	.DECIMAL_POS(DECIMAL_POS), .SP_OUT(SP_OUT), .BACKLIGHT_RED(BACKLIGHT_RED)
);

// ===== verification/testbench.sv
`timescale 1ns/10ps
module testbench;
	import sao_pkg::*;
	logic          clk        = 1'b0;
	logic          nrst       = 1'b0;
	logic          psel       = 1'b0;
	logic          penable    = 1'b0;
	logic          pwrite     = 1'b0;
	logic [AW-1:0] paddr      = '0;
	logic [31:0]   pwdata     = '0;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	sao_meas_t     meas       = '0;
	sao_man_t      man        = '0;
	logic [1:0]    slots      = 2'h2;
	logic [1:0]    chans;
	logic [1:0]    sp_out;
	logic [1:0]    relay;
	logic          red;
	int            err_total  = 0;
	int            num_checks = 0;

	// ------------------------------------------------------------
	// Clock, design and card
	// ------------------------------------------------------------
	always #10 clk = ~clk;
	// Short tick so delays fit the run
	sao_top #(.NUM_CH(2), .TICK_LEN(10)) dut (.REF_CLK(clk), .NRST(nrst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.MEAS(meas), .MAN_RST(man), .CARD_CHANNELS(chans), .BACKLIT(1'b1),
		.DECIMAL_POS(3'h2), .SP_OUT(sp_out), .BACKLIGHT_RED(red));
	sao_card_model card (.clk(clk), .slots(slots), .sp_out(sp_out),
		.channels(chans), .relay(relay));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic o(input logic [1:0] x);
		chk("sp_out", {30'h0, x}, {30'h0, sp_out});
	endtask
	// Request held until pready is seen; bounded so a hang ends the run
	task automatic apb(input logic [AW-1:0] a, input logic w,
		input logic [31:0] d, input logic e, output logic [31:0] r);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_total++;
			end_of_test();
		end
		r = prdata;
		chk("pslverr", {31'h0, e}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(a, 1'b1, d, 1'b0, r);
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [31:0] x);
		logic [31:0] r;
		apb(a, 1'b0, '0, 1'b0, r);
		chk("prdata", x, r);
	endtask
	task automatic rst();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
	endtask
	task automatic setup(input int ch, input logic [8:0] c, input int sp);
		logic [AW-1:0] b;
		b = AW'(ch) * CH_STRIDE;
		wr(b + OFF_CFG, {23'h0, c});
		wr(b + OFF_SP, 32'(sp));
		wr(b + OFF_HYST, 32'h0000000a);
	endtask
	// One display update, then time for the three stage answer
	task automatic put(input int v);
		@(posedge clk);
		meas.strobe <= 1'b1;
		meas.value <= VW'(v);
		@(posedge clk);
		meas.strobe <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic press();
		@(posedge clk);
		man.button <= 1'b1;
		repeat (2) @(posedge clk);
		man.button <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] r;
		rd(OFF_HYST, 32'h1);
		rd(OFF_SP, 32'h0);
		apb(OFF_SP, 1'b1, 32'd100000, 1'b1, r);
		apb(OFF_SP, 1'b1, -32'sd10000, 1'b1, r);
		wr(OFF_SP, -32'sd9999);
		rd(OFF_SP, 32'h3d8f1);
		apb(OFF_HYST, 1'b1, 32'h0, 1'b1, r);
		apb(OFF_HYST, 1'b1, 32'd60000, 1'b1, r);
		apb(8'h14, 1'b0, 32'h0, 1'b1, r);
		chk("unmapped", 32'h0, r);
		apb(OFF_STAT, 1'b1, 32'h0, 1'b1, r);
		apb(OFF_STAT, 1'b0, 32'h0, 1'b0, r);
		chk("decimal", 32'h2, {29'h0, r[12:10]});
	endtask
	// Every action, edges of the band from both sides
	task automatic t_act();
		int on[4] = '{105, 95, 100, 100};
		int off[4] = '{95, 105, 90, 110};
		int d;
		for (int a = 0; a < 4; a++) begin
			d = (a % 2 == 0) ? 1 : -1;
			setup(0, {6'h0, 2'(a), 1'b1}, 100);
			put(off[a]);
			o(2'b00);
			put(on[a] - d);
			o(2'b00);
			put(on[a]);
			o(2'b01);
			put(off[a] + d);
			o(2'b01);
			put(off[a]);
			o(2'b00);
		end
	endtask
	task automatic t_latch();
		setup(0, {4'h0, 2'h1, 2'h0, 1'b1}, 100);
		put(105);
		put(95);
		o(2'b01);
		put(105);
		press();
		o(2'b00);
		put(105);
		o(2'b00);
		put(95);
		put(105);
		o(2'b01);
		wr(OFF_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		o(2'b00);
	endtask
	task automatic t_defer();
		setup(0, {4'h0, 2'h2, 2'h0, 1'b1}, 100);
		put(105);
		press();
		o(2'b01);
		put(95);
		o(2'b00);
	endtask
	task automatic t_delay();
		setup(0, 9'h001, 100);
		wr(OFF_OND, 32'h3);
		wr(OFF_OFFD, 32'h3);
		put(105);
		repeat (12) @(posedge clk);
		o(2'b00);
		repeat (30) @(posedge clk);
		o(2'b01);
		put(95);
		o(2'b01);
		repeat (40) @(posedge clk);
		o(2'b00);
	endtask
	task automatic t_misc();
		setup(0, {4'hd, 2'h1, 2'h0, 1'b1}, 100);
		put(105);
		@(posedge clk);
		chk("red", 32'h1, {31'h0, red});
		man.input_shown <= 1'b1;
		press();
		o(2'b01);
		man.button_disp <= 1'b1;
		press();
		o(2'b00);
		@(posedge clk);
		meas.probe_fault <= 1'b1;
		repeat (3) @(posedge clk);
		o(2'b01);
		meas.probe_fault <= 1'b0;
	endtask
	task automatic t_chan();
		setup(1, 9'h000, 100);
		setup(0, 9'h041, 100);
		put(105);
		o(2'b00);
		put(95);
		put(105);
		o(2'b01);
		wr(CH_STRIDE + OFF_CFG, 32'h1);
		put(105);
		o(2'b11);
		chk("relay", 32'h3, {30'h0, relay});
		meas.probe_fault <= 1'b1;
		repeat (3) @(posedge clk);
		o(2'b00);
		meas.probe_fault <= 1'b0;
		slots <= 2'h1;
		repeat (6) @(posedge clk);
		o(2'b01);
		slots <= 2'h0;
		repeat (6) @(posedge clk);
		o(2'b00);
	endtask

	initial begin
		rst();
		t_regs();
		rst();
		t_act();
		rst();
		t_latch();
		rst();
		t_defer();
		rst();
		t_delay();
		rst();
		t_misc();
		rst();
		t_chan();
		end_of_test();
	end
endmodule
